// ### jump_inc_exec.sv
/*
 * Decode and execute of the absolute jump and the register increment.
 * Four phases make one instruction cycle. Assumes the fetch path shows the
 * current instruction on prog_word in phase 1 and the following program word
 * by phase 4, and that the register file answers rf_rd_data combinationally
 * from rf_addr_r. bank_sel, idx_base and ext_en come from core logic on clk.
 */
`timescale 1ns/1ps
`include "jump_inc_map.svh"

// Contract
// - Jump is two words: opcode plus target 7..0, then 1111 plus 19..8.
// - Jump target is an unsigned 20-bit literal, full range allowed.
// - Jump loads target into program counter bits 20..1; flags untouched.
// - Jump always takes two cycles and occupies two program words.
// - Increment word: 0010 10, destination bit, bank bit, 8-bit address.
// - Increment register address operand spans 0 through 255.
// - Add one; result to accumulator when d is 0, else to register.
// - Bank bit 0 resolves the address in the access bank.
// - Bank bit 1 uses bank select register to pick the bank.
// - Bank bit 0 with extended set: addresses up to 95 are indexed.
// - Increment updates carry, digit carry, negative, overflow, zero.
// - Incrementing all-ones wraps to zero, sets zero, carry, digit carry.
module jump_inc_exec
	import jump_inc_pkg::*;
(
	input  wire logic                    clk,
	input  wire logic                    rst,
	input  wire logic [15:0]             prog_word,
	input  wire logic [`BANK_W-1:0]      bank_sel,
	input  wire logic [`ADDR_W-1:0]      idx_base,
	input  wire logic                    ext_en,
	input  wire logic [7:0]              rf_rd_data,
	output jump_inc_pkg::phase_e         phase_r,
	output logic                         flush_r,
	output logic [`PC_W-1:0]             pc_target_r,
	output logic                         pc_load_r,
	output logic [`ADDR_W-1:0]           rf_addr_r,
	output logic                         rf_we_r,
	output logic [7:0]                   rf_wdata_r,
	output logic [7:0]                   w_r,
	output logic [`FLAG_W-1:0]           status_r
);
	import jump_inc_pkg::*;

	exec_s st_r;
	exec_s st_nxt;

	// Operand address: banked, access bank or indexed off the index base
	// The index sum wraps at 12 bits, so a high base can land in bank 0
	function automatic logic [`ADDR_W-1:0] resolve_addr
	(
		input logic [15:0]         word,
		input logic [`BANK_W-1:0]  bsel,
		input logic [`ADDR_W-1:0]  base,
		input logic                ext
	);
		logic [7:0] f;
		f = word[`OPND_HI:0];
		if (word[`INC_A_BIT])
			resolve_addr = {bsel, f};
		else if (ext && (f <= `IDX_MAX))
			resolve_addr = base + {4'h0, f};
		else if (f < `ACC_SPLIT)
			resolve_addr = {`ACC_LO_BANK, f};
		else
			resolve_addr = {`ACC_HI_BANK, f};
	endfunction

	// Flags produced by adding one to a byte
	function automatic logic [`FLAG_W-1:0] inc_flags
	(
		input logic [7:0] d
	);
		logic [8:0] sum;
		sum = {1'b0, d} + {1'b0, `BYTE_ONE};
		inc_flags = `STATUS_RST;
		inc_flags[`FLAG_C]  = sum[8];
		inc_flags[`FLAG_DC] = (d[3:0] == `NIB_ONES);
		inc_flags[`FLAG_Z]  = (sum[7:0] == `BYTE_ZERO);
		inc_flags[`FLAG_OV] = (d == `BYTE_MAXPOS);
		inc_flags[`FLAG_N]  = sum[7];
	endfunction

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.pc_load = 1'b0;
		st_nxt.rf_we = 1'b0;
		unique case (st_r.phase)
			PH_Q1:
			begin
				st_nxt.phase = PH_Q2;
				st_nxt.ir = prog_word;
				st_nxt.kind = K_NONE;
				// The fetched word after a jump is discarded, not decoded
				if (!st_r.flush)
				begin
					if (prog_word[`JMP_OPC_HI:`JMP_OPC_LO] == `JMP_OPC)
						st_nxt.kind = K_JUMP;
					else if (prog_word[`INC_OPC_HI:`INC_OPC_LO] == `INC_OPC)
					begin
						st_nxt.kind = K_INC;
						st_nxt.dest = prog_word[`INC_D_BIT];
						st_nxt.rf_addr = resolve_addr(prog_word, bank_sel,
							idx_base, ext_en);
					end
				end
			end
			PH_Q2:
			begin
				st_nxt.phase = PH_Q3;
				if (st_r.kind == K_JUMP)
					st_nxt.k_lo = st_r.ir[`OPND_HI:0];
				if (st_r.kind == K_INC)
					st_nxt.data = rf_rd_data;
			end
			PH_Q3:
			begin
				st_nxt.phase = PH_Q4;
				if (st_r.kind == K_INC)
				begin
					st_nxt.result = st_r.data + `BYTE_ONE;
					st_nxt.flags_new = inc_flags(st_r.data);
				end
			end
			PH_Q4:
			begin
				st_nxt.phase = PH_Q1;
				st_nxt.flush = 1'b0;
				if (st_r.kind == K_JUMP)
				begin
					// Flush holds for the whole next cycle; status left alone
					st_nxt.flush = 1'b1;
					// A bad second word loads nothing but still drops the fetched word
					if (prog_word[`JMP_PFX_HI:`JMP_PFX_LO] == `JMP_PFX)
					begin
						st_nxt.pc_target = {prog_word[`JMP_UPPER_HI:0],
							st_r.k_lo, 1'b0};
						st_nxt.pc_load = 1'b1;
					end
				end
				if (st_r.kind == K_INC)
				begin
					st_nxt.status = st_r.flags_new;
					if (st_r.dest)
					begin
						st_nxt.rf_we = 1'b1;
						st_nxt.rf_wdata = st_r.result;
					end
					else
						st_nxt.w = st_r.result;
				end
				st_nxt.kind = K_NONE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			st_r.phase <= PH_Q1;
			st_r.kind <= K_NONE;
			st_r.flush <= 1'b0;
			st_r.ir <= `WORD_ZERO;
			st_r.k_lo <= `BYTE_ZERO;
			st_r.dest <= 1'b0;
			st_r.data <= `BYTE_ZERO;
			st_r.result <= `BYTE_ZERO;
			st_r.flags_new <= `STATUS_RST;
			st_r.rf_addr <= {`ACC_LO_BANK, `BYTE_ZERO};
			st_r.rf_we <= 1'b0;
			st_r.rf_wdata <= `BYTE_ZERO;
			st_r.w <= `W_RST;
			st_r.status <= `STATUS_RST;
			st_r.pc_target <= `PC_ZERO;
			st_r.pc_load <= 1'b0;
		end
		else
			st_r <= st_nxt;
	end

	assign phase_r     = st_r.phase;
	assign flush_r     = st_r.flush;
	assign pc_target_r = st_r.pc_target;
	assign pc_load_r   = st_r.pc_load;
	assign rf_addr_r   = st_r.rf_addr;
	assign rf_we_r     = st_r.rf_we;
	assign rf_wdata_r  = st_r.rf_wdata;
	assign w_r         = st_r.w;
	assign status_r    = st_r.status;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_jump_upper_load: assert property (
		(st_r.phase == PH_Q4 && st_r.kind == K_JUMP
			&& prog_word[`JMP_PFX_HI:`JMP_PFX_LO] == `JMP_PFX)
		|=> pc_load_r && pc_target_r[`TGT_W:9] == $past(prog_word[`JMP_UPPER_HI:0]))
		else $error("jump upper target not loaded from second word");

	a_jump_low_byte: assert property (
		(st_r.phase == PH_Q1 && !flush_r
			&& prog_word[`JMP_OPC_HI:`JMP_OPC_LO] == `JMP_OPC
			&& prog_word[`JMP_PFX_HI:`JMP_PFX_LO] != `JMP_PFX)
		##3 (prog_word[`JMP_PFX_HI:`JMP_PFX_LO] == `JMP_PFX)
		|=> pc_target_r[8:0] == {$past(st_r.ir[`OPND_HI:0], 1), 1'b0})
		else $error("jump low target byte or word alignment wrong");

	a_jump_no_flags: assert property (
		(st_r.phase == PH_Q4 && st_r.kind == K_JUMP) |=> $stable(status_r)
		##1 $stable(status_r)[*3])
		else $error("jump changed status flags");

	a_jump_two_cycle: assert property (
		pc_load_r |-> flush_r[*4] ##1 !flush_r)
		else $error("jump did not last exactly two cycles");

	a_flush_no_exec: assert property (
		(st_r.phase == PH_Q1 && flush_r) |=> st_r.kind == K_NONE
		##1 !rf_we_r [*3])
		else $error("flushed word was executed");

	a_inc_to_reg: assert property (
		(st_r.phase == PH_Q4 && st_r.kind == K_INC && st_r.dest)
		|=> rf_we_r && rf_wdata_r == $past(st_r.data) + `BYTE_ONE)
		else $error("increment result not written back to register");

	a_inc_to_w: assert property (
		(st_r.phase == PH_Q4 && st_r.kind == K_INC && !st_r.dest)
		|=> !rf_we_r && w_r == $past(st_r.data) + `BYTE_ONE)
		else $error("increment result not placed in accumulator");

	a_bank_select: assert property (
		(st_r.phase == PH_Q1 && !flush_r
			&& prog_word[`INC_OPC_HI:`INC_OPC_LO] == `INC_OPC
			&& prog_word[`INC_A_BIT])
		|=> rf_addr_r == {$past(bank_sel), $past(prog_word[`OPND_HI:0])})
		else $error("banked address not taken from bank select");

	a_access_bank: assert property (
		(st_r.phase == PH_Q1 && !flush_r && !ext_en
			&& prog_word[`INC_OPC_HI:`INC_OPC_LO] == `INC_OPC
			&& !prog_word[`INC_A_BIT] && prog_word[`OPND_HI:0] < `ACC_SPLIT)
		|=> rf_addr_r == {`ACC_LO_BANK, $past(prog_word[`OPND_HI:0])})
		else $error("access bank address wrong");

	a_indexed_mode: assert property (
		(st_r.phase == PH_Q1 && !flush_r && ext_en
			&& prog_word[`INC_OPC_HI:`INC_OPC_LO] == `INC_OPC
			&& !prog_word[`INC_A_BIT] && prog_word[`OPND_HI:0] <= `IDX_MAX)
		|=> rf_addr_r == $past(idx_base) + {4'h0, $past(prog_word[`OPND_HI:0])})
		else $error("indexed literal offset address wrong");

	a_wrap_flags: assert property (
		(st_r.phase == PH_Q4 && st_r.kind == K_INC && st_r.data == 8'hFF)
		|=> status_r[`FLAG_Z] && status_r[`FLAG_C] && status_r[`FLAG_DC]
			&& !status_r[`FLAG_N])
		else $error("all-ones increment flags wrong");

	a_inc_phases: assert property (
		(st_r.phase == PH_Q1 && !flush_r
			&& prog_word[`INC_OPC_HI:`INC_OPC_LO] == `INC_OPC
			&& prog_word[`INC_D_BIT])
		|=> !rf_we_r ##1 !rf_we_r ##1 !rf_we_r ##1 rf_we_r)
		else $error("increment write not in phase four");

	a_access_high: assert property (
		(st_r.phase == PH_Q1 && !flush_r
			&& prog_word[`INC_OPC_HI:`INC_OPC_LO] == `INC_OPC
			&& !prog_word[`INC_A_BIT] && prog_word[`OPND_HI:0] >= `ACC_SPLIT)
		|=> rf_addr_r == {`ACC_HI_BANK, $past(prog_word[`OPND_HI:0])})
		else $error("upper access bank address wrong");

	a_other_word_idle: assert property (
		(st_r.phase == PH_Q1 && !flush_r
			&& prog_word[`JMP_OPC_HI:`JMP_OPC_LO] != `JMP_OPC
			&& prog_word[`INC_OPC_HI:`INC_OPC_LO] != `INC_OPC)
		|=> st_r.kind == K_NONE)
		else $error("unknown word was decoded");

	a_inc_flag_set: assert property (
		(st_r.phase == PH_Q4 && st_r.kind == K_INC)
		|=> status_r[`FLAG_OV] == ($past(st_r.data) == `BYTE_MAXPOS)
			&& status_r[`FLAG_N] == $past(st_r.result[`OPND_HI])
			&& status_r[`FLAG_Z] == ($past(st_r.result) == `BYTE_ZERO))
		else $error("increment flags do not follow the result");

	a_pc_word_align: assert property (pc_target_r[0] == 1'b0)
		else $error("jump target not word aligned");

	a_jump_no_write: assert property (
		(st_r.phase == PH_Q4 && st_r.kind == K_JUMP) |=> !rf_we_r)
		else $error("jump wrote the register file");

	c_jump: cover property (pc_load_r ##4 !flush_r);
	c_inc_reg: cover property (rf_we_r);
	c_inc_w: cover property (st_r.phase == PH_Q4 && st_r.kind == K_INC && !st_r.dest);
	c_wrap: cover property (st_r.phase == PH_Q4 && st_r.kind == K_INC
		&& st_r.data == 8'hFF);
	c_indexed: cover property (st_r.phase == PH_Q1 && !flush_r && ext_en
		&& prog_word[`INC_OPC_HI:`INC_OPC_LO] == `INC_OPC && !prog_word[`INC_A_BIT]);

endmodule

// ### jump_inc_map.svh
/*
 * Encodings, field positions, reset values and address constants for the
 * jump and increment executor. Definitions only; included by bare name.
 */
`ifndef JUMP_INC_MAP_SVH
`define JUMP_INC_MAP_SVH

// First jump word: top byte is the opcode, low byte carries target 7..0
`define JMP_OPC       8'hEF
`define JMP_OPC_HI    15
`define JMP_OPC_LO    8
// Second jump word: top nibble prefix, low 12 bits carry target 19..8
`define JMP_PFX       4'hF
`define JMP_PFX_HI    15
`define JMP_PFX_LO    12
`define JMP_UPPER_HI  11
// Increment word: 6-bit opcode, destination bit, bank bit, 8-bit address
`define INC_OPC       6'h0A
`define INC_OPC_HI    15
`define INC_OPC_LO    10
`define INC_D_BIT     9
`define INC_A_BIT     8
`define OPND_HI       7
// Access bank split and indexed literal offset limit
`define ACC_SPLIT     8'h60
`define IDX_MAX       8'h5F
`define ACC_LO_BANK   4'h0
`define ACC_HI_BANK   4'hF
// Widths
`define PC_W          21
`define TGT_W         20
`define ADDR_W        12
`define BANK_W        4
`define FLAG_W        5
// Status bit positions
`define FLAG_C        0
`define FLAG_DC       1
`define FLAG_Z        2
`define FLAG_OV       3
`define FLAG_N        4
// Reset values and arithmetic constants
`define STATUS_RST    5'h00
`define W_RST         8'h00
`define BYTE_ZERO     8'h00
`define BYTE_ONE      8'h01
`define BYTE_MAXPOS   8'h7F
`define NIB_ONES      4'hF
`define WORD_ZERO     16'h0000
`define PC_ZERO       21'h000000

`endif

// ### jump_inc_pkg.sv
/*
 * Types shared by the jump and increment executor: phase and kind enums and
 * the packed state record. Assumes jump_inc_map.svh is on the include path.
 */
`include "jump_inc_map.svh"

package jump_inc_pkg;

	typedef enum logic [1:0]
	{
		PH_Q1 = 2'b00,
		PH_Q2 = 2'b01,
		PH_Q3 = 2'b10,
		PH_Q4 = 2'b11
	} phase_e;

	typedef enum logic [1:0]
	{
		K_NONE = 2'b00,
		K_JUMP = 2'b01,
		K_INC  = 2'b10
	} kind_e;

	typedef struct packed
	{
		phase_e                 phase;
		kind_e                  kind;
		logic                   flush;
		logic [15:0]            ir;
		logic [7:0]             k_lo;
		logic                   dest;
		logic [7:0]             data;
		logic [7:0]             result;
		logic [`FLAG_W-1:0]     flags_new;
		logic [`ADDR_W-1:0]     rf_addr;
		logic                   rf_we;
		logic [7:0]             rf_wdata;
		logic [7:0]             w;
		logic [`FLAG_W-1:0]     status;
		logic [`PC_W-1:0]       pc_target;
		logic                   pc_load;
	} exec_s;

endpackage

// ### rf_model.sv
/*
 * Register file model on the far side of the executor.
 * Assumes reads are combinational from the address and writes land on clk.
 */
`timescale 1ns/1ps
`include "jump_inc_map.svh"
module rf_model
(
	input  wire logic               clk,
	input  wire logic [`ADDR_W-1:0] addr,
	input  wire logic               we,
	input  wire logic [7:0]         wdata,
	output logic [7:0]              rd_data
);
	logic [7:0] mem [0:(1<<`ADDR_W)-1];
	// Unloaded cells read as unknown, so a stray address cannot pass as a match
	assign rd_data = mem[addr];
	always @(posedge clk)
	begin
		if (we)
			mem[addr] <= wdata;
	end
endmodule

// ### jump_and_increment_exec_bench.sv
/*
 * Self-checking bench for the jump and increment executor.
 * Assumes the executor package and the register file model are compiled first.
 */
`timescale 1ns/1ps
`include "jump_inc_map.svh"
module jump_and_increment_exec_bench;
	import jump_inc_pkg::*;
	logic                clk = 1'b0;
	logic                rst = 1'b1;
	logic [15:0]         prog_word = 16'h0000;
	logic [`BANK_W-1:0]  bank_sel = 4'h0;
	logic [`ADDR_W-1:0]  idx_base = 12'h000;
	logic                ext_en = 1'b0;
	logic [7:0]          rf_rd_data;
	phase_e              phase_r;
	logic                flush_r;
	logic [`PC_W-1:0]    pc_target_r;
	logic                pc_load_r;
	logic [`ADDR_W-1:0]  rf_addr_r;
	logic                rf_we_r;
	logic [7:0]          rf_wdata_r;
	logic [7:0]          w_r;
	logic [`FLAG_W-1:0]  status_r;
	int                  n_mismatch = 0;
	int                  comparisons = 0;

	always #10 clk = ~clk;

	jump_inc_exec dut_u (.clk(clk), .rst(rst), .prog_word(prog_word), .bank_sel(bank_sel),
		.idx_base(idx_base), .ext_en(ext_en), .rf_rd_data(rf_rd_data), .phase_r(phase_r),
		.flush_r(flush_r), .pc_target_r(pc_target_r), .pc_load_r(pc_load_r),
		.rf_addr_r(rf_addr_r), .rf_we_r(rf_we_r), .rf_wdata_r(rf_wdata_r), .w_r(w_r),
		.status_r(status_r));
	rf_model rf_u (.clk(clk), .addr(rf_addr_r), .we(rf_we_r), .wdata(rf_wdata_r),
		.rd_data(rf_rd_data));

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [20:0] got, input logic [20:0] exp, input string what);
		comparisons++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask

	// Presents w1 in Q1 and w2 in Q4, returns settled just after the edge ending Q4
	task automatic issue(input logic [15:0] w1, input logic [15:0] w2);
		int n;
		n = 0;
		while (phase_r !== PH_Q1 && n < 8)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		chk(phase_r, PH_Q1, "phase align");
		prog_word = w1;
		repeat (3) @(posedge clk);
		#1;
		prog_word = w2;
		@(posedge clk);
		#1;
	endtask

	// Feeds an increment during the flushed cycle; it must be dropped
	task automatic flush_tail();
		logic [`ADDR_W-1:0] ad;
		ad = rf_addr_r;
		chk(flush_r, 1'b1, "flush set");
		prog_word = 16'h2A00;
		repeat (4)
		begin
			@(posedge clk);
			#1;
			chk(pc_load_r, 1'b0, "load pulse");
			chk(rf_we_r, 1'b0, "flushed write");
		end
		prog_word = 16'h0000;
		chk(flush_r, 1'b0, "flush end");
		chk(rf_addr_r, ad, "flushed decode");
	endtask

	task automatic t_jump(input logic [19:0] tgt);
		logic [`FLAG_W-1:0] st;
		st = status_r;
		issue({`JMP_OPC, tgt[7:0]}, {`JMP_PFX, tgt[19:8]});
		chk(pc_load_r, 1'b1, "jump load");
		chk(pc_target_r, {tgt, 1'b0}, "jump target");
		chk(status_r, st, "jump flags");
		flush_tail();
	endtask

	task automatic t_bad_jump();
		logic [`PC_W-1:0] pt;
		pt = pc_target_r;
		issue(16'hEF12, 16'h0345);
		chk(pc_load_r, 1'b0, "bad prefix load");
		chk(pc_target_r, pt, "bad prefix target");
		flush_tail();
	endtask

	// Reset in the middle of an increment: every output but rf_wdata_r checked back at idle, phase to Q1
	task automatic t_reset();
		prog_word = 16'h2B10;
		repeat (2) @(posedge clk);
		#1;
		rst = 1'b1;
		@(posedge clk);
		#1;
		chk(phase_r, PH_Q1, "reset phase");
		chk(flush_r, 1'b0, "reset flush");
		chk(pc_load_r, 1'b0, "reset load");
		chk(pc_target_r, `PC_ZERO, "reset target");
		chk(rf_addr_r, 12'h000, "reset address");
		chk(rf_we_r, 1'b0, "reset write");
		chk(w_r, 8'h00, "reset accumulator");
		chk(status_r, 5'h00, "reset flags");
		prog_word = 16'h0000;
		repeat (2) @(posedge clk);
		#1;
		rst = 1'b0;
	endtask

	task automatic t_inc(input logic [15:0] word, input logic [3:0] bsel, input logic ext,
		input logic [11:0] base, input logic [7:0] val, input logic [11:0] addr);
		logic [7:0]         res;
		logic [7:0]         w0;
		logic [`FLAG_W-1:0] fl;
		res = val + 8'h01;
		fl = '0;
		fl[`FLAG_C] = (val == 8'hFF);
		fl[`FLAG_DC] = (val[3:0] == 4'hF);
		fl[`FLAG_Z] = (res == 8'h00);
		fl[`FLAG_OV] = (val == 8'h7F);
		fl[`FLAG_N] = res[7];
		bank_sel = bsel;
		ext_en = ext;
		idx_base = base;
		rf_u.mem[addr] = val;
		w0 = w_r;
		issue(word, 16'h0000);
		chk(rf_addr_r, addr, "operand address");
		chk(status_r, fl, "inc flags");
		chk(rf_we_r, word[9], "write pulse");
		chk(w_r, word[9] ? w0 : res, "accumulator");
		if (word[9])
			chk(rf_wdata_r, res, "write data");
	endtask

	initial
	begin
		#(20 * 3000);
		n_mismatch++;
		summarize();
	end

	initial
	begin
		repeat (3) @(posedge clk);
		#1;
		rst = 1'b0;
		t_inc(16'h2B10, 4'h3, 1'b0, 12'h000, 8'hFF, 12'h310);
		t_inc(16'h2870, 4'h3, 1'b0, 12'h000, 8'h7F, 12'hF70);
		t_inc(16'h2850, 4'h3, 1'b0, 12'h000, 8'h0F, 12'h050);
		t_inc(16'h2A05, 4'h3, 1'b1, 12'h200, 8'h41, 12'h205);
		t_inc(16'h2A60, 4'h3, 1'b1, 12'h200, 8'h80, 12'hF60);
		t_inc(16'h2BFF, 4'hA, 1'b1, 12'h200, 8'h00, 12'hAFF);
		t_jump(20'h56734);
		t_jump(20'h00000);
		t_jump(20'hFFFFF);
		t_reset();
		t_bad_jump();
		t_inc(16'h29FF, 4'h5, 1'b0, 12'h000, 8'hFE, 12'h5FF);
		summarize();
	end
endmodule
